// file: hw/slps_map.vh
// Register map, field positions and reset values of the link
// parameter and status bank. Definitions only.
`ifndef SLPS_MAP_VH
`define SLPS_MAP_VH

// Register indices; byte address is four times the index
`define SLPS_IDX_DEVNUM     12'h206
`define SLPS_IDX_COMMA      12'h207
`define SLPS_IDX_STATUS     12'h208
`define SLPS_IDX_CHEN       12'h209
`define SLPS_IDX_LINKCTL    12'h300
`define SLPS_IDX_IRQ_STAT   12'h301
`define SLPS_IDX_IRQ_MASK   12'h302

// Reset values
`define SLPS_RST_DEVNUM     8'h00
`define SLPS_RST_COMMA      8'h00
`define SLPS_RST_CHEN       8'h03
`define SLPS_RST_LINKCTL    8'h00
`define SLPS_RST_IRQ_MASK   8'h00

// Status bit positions
`define SLPS_ST_LINK_UP     6
`define SLPS_ST_SYNC        5
`define SLPS_ST_REALIGN     4
`define SLPS_ST_MF_SET      3
`define SLPS_ST_SPLL        2
`define SLPS_ST_CPLL        0

// Channel enable bit positions
`define SLPS_CH_FIRST       0
`define SLPS_CH_SECOND      1
`define SLPS_CH_SINGLE      2

// Comma selection codes and 8B/10B K-characters
`define SLPS_COMMA_K287     2'h0
`define SLPS_COMMA_K281     2'h1
`define SLPS_COMMA_K285     2'h2
`define SLPS_K28_7          8'hfc
`define SLPS_K28_1          8'h3c
`define SLPS_K28_5          8'hbc

// Interrupt status bit positions (events)
`define SLPS_IRQ_REALIGN    0
`define SLPS_IRQ_MF_SET     1
`define SLPS_IRQ_LINK_DOWN  2
`define SLPS_IRQ_PLL_LOSS   3

`endif

// file: hw/slps_sync2.v
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes the inputs are static levels, not pulses.
`timescale 1ns/1ps

module slps_sync2 #(
    parameter W = 4
) (
    // Clock and reset
    input  wire         clk_in,
    input  wire         rst_n_in,
    // Levels
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    // First stage feeds only the second
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule

// file: hw/slps_regs.v
// Parameter and status register bank of the serial transmit link,
// with APB slave, event interrupt and frame configuration outputs.
// Assumes the link core, PLLs and SYSREF logic run on clk_in; PLL lock
// and the sync pin are asynchronous and are synchronised here.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "slps_map.vh"

// Operation
// RULE_01 - Device ID register value is sent in ILA second multiframe.
// RULE_02 - Software changes ID and comma settings only with link disabled.
// RULE_03 - Two-bit comma select: 0 K28.7, 1 K28.1, 2 K28.5, 3 reserved.
// RULE_04 - Comma choice only matters in 8B/10B modes, ignored for 64B/66B.
// RULE_05 - Software keeps 0 for compliant receivers, 1 or 2 otherwise.
// RULE_06 - Status bit 6 high while link is up.
// RULE_07 - Status bit 5 reads 0 when sync request asserted, else 1.
// RULE_08 - Status bit 4 set when SYSREF shifts a block clock phase.
// RULE_09 - Both alignment flags sticky, cleared by writing one.
// RULE_10 - Status bit 3 set by first SYSREF after encoder enable.
// RULE_11 - Status bit 2 follows serializer PLL lock.
// RULE_12 - Status bit 0 follows converter PLL lock.
// RULE_13 - Channel bits: pair AB, pair CD, single mode needing AB.
// RULE_14 - Software disables calibration and link before channel changes.
// RULE_15 - One pair off: half converters, ceil half lanes, tail padding.
// RULE_16 - With AB off, CD samples take the AB frame positions.
// RULE_17 - Writes never change the live status bits.
module slps_regs (
    // Clock and reset
    input  wire        clk_in,
    input  wire        rst_n_in,
    // APB slave
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [13:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out,
    // Link core status, same clock domain
    input  wire        link_up_in,
    input  wire        sysref_phase_shift_in,
    input  wire        sysref_event_in,
    input  wire        mode_64b66b_in,
    input  wire [3:0]  full_lanes_in,
    input  wire [3:0]  full_converters_in,
    // Asynchronous pins
    input  wire        sync_n_pin_in,
    input  wire        serializer_pll_lock_in,
    input  wire        converter_pll_lock_in,
    // Configuration to the link core
    output reg         serial_link_enable_out,
    output reg  [7:0]  link_device_number_out,
    output reg  [7:0]  frame_end_comma_out,
    output reg         comma_valid_out,
    output reg         first_pair_enable_out,
    output reg         second_pair_enable_out,
    output reg         single_channel_select_out,
    output reg         pair_swap_out,
    output reg  [3:0]  active_lanes_out,
    output reg  [3:0]  active_converters_out,
    output reg         tail_pad_out,
    // Interrupt
    output reg         irq_out
);

    // Registers
    reg  [7:0]  link_device_identifier_reg;
    reg  [1:0]  frame_end_comma_select_reg;
    reg  [7:0]  channel_pair_enable_reg;
    reg         serial_link_enable_reg;
    reg         realign_flag_reg;
    reg         multiframe_phase_set_flag_reg;
    reg         first_sysref_seen_reg;
    reg  [3:0]  irq_stat_reg;
    reg  [3:0]  irq_mask_reg;
    reg         link_up_d_reg;
    reg         plls_d_reg;
    reg  [7:0]  rdata_next;
    reg         err_next;

    // Synchronised pins
    wire [2:0]  pins_sync;
    wire        sync_n_s;
    wire        serializer_pll_lock;
    wire        converter_pll_lock;

    // Bus qualifiers
    // Index drops the byte lane bits
    wire        setup_ph;
    wire        wr_acc;
    wire        rd_acc;
    wire [11:0] idx;
    wire [7:0]  wbyte;
    wire [7:0]  status_live;
    wire        plls_now;
    wire [3:0]  irq_events;

    // Pin levels: bits 5, 2, 0 lag two clocks
    slps_sync2 #(
        .W (3)
    ) u_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .async_in ({sync_n_pin_in, serializer_pll_lock_in,
                    converter_pll_lock_in}),
        .sync_out (pins_sync)
    );

    assign sync_n_s            = pins_sync[2];
    assign serializer_pll_lock = pins_sync[1];
    assign converter_pll_lock  = pins_sync[0];

    // Word index from byte address; low two bits ignored
    function [11:0] word_idx;
        input [13:0] a;
        begin
            word_idx = a[13:2];
        end
    endfunction

    // Comma K-character from select code
    // Code 3 is reserved: K28.7
    function [7:0] comma_char;
        input [1:0] sel;
        begin
            case (sel)
                `SLPS_COMMA_K287: comma_char = `SLPS_K28_7;
                `SLPS_COMMA_K281: comma_char = `SLPS_K28_1;
                `SLPS_COMMA_K285: comma_char = `SLPS_K28_5;
                default:          comma_char = `SLPS_K28_7;
            endcase
        end
    endfunction

    // Ceiling of half a count
    // Lanes only; converters halve exactly
    function [3:0] half_up;
        input [3:0] n;
        begin
            half_up = {1'b0, n[3:1]} + {3'h0, n[0]};
        end
    endfunction

    // Access phase: one wait-free cycle, answer given in setup
    // Writes commit at the pready edge
    assign setup_ph = psel_in & ~penable_in;
    assign idx      = word_idx(paddr_in);
    assign wbyte    = pwdata_in[7:0];
    assign wr_acc   = psel_in & penable_in & pready_out & pwrite_in;
    assign rd_acc   = setup_ph & ~pwrite_in;
    assign plls_now = serializer_pll_lock & converter_pll_lock;

    // Live status view; bits 7 and 1 read zero
    assign status_live = {1'b0, // see RULE_17
                          link_up_in,                    // see RULE_06
                          sync_n_s,                      // see RULE_07
                          realign_flag_reg,
                          multiframe_phase_set_flag_reg,
                          serializer_pll_lock,           // see RULE_11
                          1'b0,
                          converter_pll_lock};           // see RULE_12

    // Interrupt events: alignment flags and losses of link or lock
    // Either PLL dropping is a loss
    assign irq_events = {plls_d_reg & ~plls_now,
                         link_up_d_reg & ~link_up_in,
                         sysref_event_in & ~first_sysref_seen_reg
                             & serial_link_enable_reg,
                         sysref_phase_shift_in};

    // Read decode, registered one cycle later as answer
    // Unmapped index: zero and error
    always @* begin
        rdata_next = 8'h00;
        err_next   = 1'b0;
        case (idx)
            `SLPS_IDX_DEVNUM:   rdata_next = link_device_identifier_reg;
            `SLPS_IDX_COMMA:    rdata_next = {6'h00,
                                              frame_end_comma_select_reg};
            `SLPS_IDX_STATUS:   rdata_next = status_live;
            `SLPS_IDX_CHEN:     rdata_next = channel_pair_enable_reg;
            `SLPS_IDX_LINKCTL:  rdata_next = {7'h00, serial_link_enable_reg};
            `SLPS_IDX_IRQ_STAT: rdata_next = {4'h0, irq_stat_reg};
            `SLPS_IDX_IRQ_MASK: rdata_next = {4'h0, irq_mask_reg};
            default:            err_next   = 1'b1;
        endcase
    end

    // Read data caught at setup, so it
    // already stands with pready
    // APB answer: pready high in every access phase, zero wait
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_out  <= 1'b0;
            prdata_out  <= 32'h00000000;
            pslverr_out <= 1'b0;
        end else begin
            pready_out  <= setup_ph;
            pslverr_out <= setup_ph & err_next;
            if (rd_acc) begin
                prdata_out <= {24'h000000, rdata_next};
            end else if (setup_ph) begin
                prdata_out <= 32'h00000000;
            end
        end
    end

    // Writable configuration; sticky flags live in the next process
    // Channel bits 7:3 dropped, read zero
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link_device_identifier_reg <= `SLPS_RST_DEVNUM;
            frame_end_comma_select_reg <= 2'h0;
            channel_pair_enable_reg    <= `SLPS_RST_CHEN;
            serial_link_enable_reg     <= 1'b0;
            irq_mask_reg               <= 4'h0;
        end else if (wr_acc) begin
            case (idx)
                // Stored as written; software keeps link off meanwhile
                `SLPS_IDX_DEVNUM: begin
                    link_device_identifier_reg <= wbyte; // see RULE_02
                end
                `SLPS_IDX_COMMA: begin
                    frame_end_comma_select_reg <= wbyte[1:0]; // see RULE_05
                end
                `SLPS_IDX_CHEN: begin
                    channel_pair_enable_reg <= {5'h00, wbyte[2:0]};
                end
                `SLPS_IDX_LINKCTL: begin
                    serial_link_enable_reg <= wbyte[0];
                end
                `SLPS_IDX_IRQ_MASK: begin
                    irq_mask_reg <= wbyte[3:0];
                end
                default: begin
                    irq_mask_reg <= irq_mask_reg;
                end
            endcase
        end
    end

    // Last-cycle copies reset to idle low,
    // so no false loss event after reset
    // Sticky flags: set beats a same-cycle write-one clear
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            realign_flag_reg              <= 1'b0;
            multiframe_phase_set_flag_reg <= 1'b0;
            first_sysref_seen_reg         <= 1'b0;
            irq_stat_reg                  <= 4'h0;
            link_up_d_reg                 <= 1'b0;
            plls_d_reg                    <= 1'b0;
        end else begin
            link_up_d_reg <= link_up_in;
            plls_d_reg    <= plls_now;
            // Write-one clear, status bits 6,5,2,0 ignore writes
            if (wr_acc && idx == `SLPS_IDX_STATUS) begin
                if (wbyte[`SLPS_ST_REALIGN]) begin
                    realign_flag_reg <= 1'b0;              // see RULE_09
                end
                if (wbyte[`SLPS_ST_MF_SET]) begin
                    multiframe_phase_set_flag_reg <= 1'b0; // see RULE_09
                end
            end
            if (sysref_phase_shift_in) begin
                realign_flag_reg <= 1'b1;                  // see RULE_08
            end
            // Re-armed each time the encoder is disabled
            if (!serial_link_enable_reg) begin
                first_sysref_seen_reg <= 1'b0;
            end else if (sysref_event_in && !first_sysref_seen_reg) begin
                first_sysref_seen_reg         <= 1'b1;
                multiframe_phase_set_flag_reg <= 1'b1;     // see RULE_10
            end
            if (wr_acc && idx == `SLPS_IDX_IRQ_STAT) begin
                irq_stat_reg <= (irq_stat_reg & ~wbyte[3:0]) | irq_events;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_events;
            end
        end
    end

    // Live status bits have no storage;
    // writes to them have no effect and
    // reads always show the inputs

    // Configuration outputs registered from the bank
    // One clock behind the bank; no glitches
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            serial_link_enable_out    <= 1'b0;
            link_device_number_out    <= `SLPS_RST_DEVNUM;
            frame_end_comma_out       <= `SLPS_K28_7;
            comma_valid_out           <= 1'b0;
            first_pair_enable_out     <= 1'b1;
            second_pair_enable_out    <= 1'b1;
            single_channel_select_out <= 1'b0;
            pair_swap_out             <= 1'b0;
            active_lanes_out          <= 4'h0;
            active_converters_out     <= 4'h0;
            tail_pad_out              <= 1'b0;
            irq_out                   <= 1'b0;
        end else begin
            serial_link_enable_out <= serial_link_enable_reg;
            // ID sent in ILA second multiframe by the core
            link_device_number_out <=
                link_device_identifier_reg;             // see RULE_01
            // Reserved code falls back to the compliant comma
            frame_end_comma_out <= comma_char(frame_end_comma_select_reg);
            // see RULE_03, see RULE_04
            comma_valid_out <= ~mode_64b66b_in;
            // Single mode only honoured with first pair on; see RULE_13
            first_pair_enable_out <=
                channel_pair_enable_reg[`SLPS_CH_FIRST];
            second_pair_enable_out <=
                channel_pair_enable_reg[`SLPS_CH_SECOND]
                & ~(channel_pair_enable_reg[`SLPS_CH_SINGLE]
                    & channel_pair_enable_reg[`SLPS_CH_FIRST]);
            single_channel_select_out <=
                channel_pair_enable_reg[`SLPS_CH_SINGLE]
                & channel_pair_enable_reg[`SLPS_CH_FIRST];
            // see RULE_16
            pair_swap_out <= ~channel_pair_enable_reg[`SLPS_CH_FIRST];
            // Halve when exactly one pair is on; see RULE_15
            // Odd lane count pads the top lane
            if (channel_pair_enable_reg[`SLPS_CH_FIRST]
                ^ channel_pair_enable_reg[`SLPS_CH_SECOND]) begin
                active_lanes_out      <= half_up(full_lanes_in);
                active_converters_out <= {1'b0, full_converters_in[3:1]};
                tail_pad_out          <= full_lanes_in[0];
            end else begin
                active_lanes_out      <= full_lanes_in;
                active_converters_out <= full_converters_in;
                tail_pad_out          <= 1'b0;
            end
            // Level interrupt from masked sticky events
            // Masking hides, never clears
            irq_out <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // RULE_14 is software's duty; channel writes are taken as they come
endmodule

// file: bench/slps_checker.sv
// Concurrent checks on the ports of the link parameter and status bank.
// Assumes one clock domain and APB transfers of setup then access.
`timescale 1ns/1ps
module slps_checker (
    // Clock, reset and APB
    input wire        clk_in, rst_n_in, psel_in, penable_in,
    input wire        pwrite_in, pready_out,
    input wire [13:0] paddr_in,
    input wire [31:0] pwdata_in, prdata_out,
    // Link side
    input wire        link_up_in, sysref_phase_shift_in, mode_64b66b_in,
    input wire        sync_n_pin_in, serializer_pll_lock_in,
    input wire        converter_pll_lock_in,
    input wire [3:0]  full_lanes_in, full_converters_in,
    // Configuration outputs
    input wire [7:0]  link_device_number_out, frame_end_comma_out,
    input wire        comma_valid_out, first_pair_enable_out,
    input wire        second_pair_enable_out, single_channel_select_out,
    input wire        tail_pad_out,
    input wire [3:0]  active_lanes_out, active_converters_out
);
    logic       rd_st, wr_ok;
    logic [1:0] pll_pair;
    logic [4:0] lanes_up;
    logic [7:0] dev_w_reg, comma_w_reg;

    // Bus phases and derived figures
    assign rd_st = psel_in && !penable_in && !pwrite_in
                   && paddr_in[13:2] == 12'h208;
    assign wr_ok = psel_in && penable_in && pready_out && pwrite_in;
    assign pll_pair = {serializer_pll_lock_in, converter_pll_lock_in};
    assign lanes_up = {1'b0, full_lanes_in} + 5'h01;

    // Last committed ID and comma bytes
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dev_w_reg   <= 8'h00;
            comma_w_reg <= 8'h00;
        end else if (wr_ok && paddr_in[13:2] == 12'h206) begin
            dev_w_reg <= pwdata_in[7:0];
        end else if (wr_ok && paddr_in[13:2] == 12'h207) begin
            comma_w_reg <= pwdata_in[7:0];
        end
    end

    // Code 3 is reserved and falls back to the compliant comma
    function automatic logic [7:0] kchar(input logic [1:0] c);
        kchar = (c == 2'h1) ? 8'h3c : (c == 2'h2) ? 8'hbc : 8'hfc;
    endfunction

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_devnum_drive: assert property (
        wr_ok && paddr_in[13:2] == 12'h206 |-> ##2
        link_device_number_out == dev_w_reg) else $error("device number");
    a_comma_code: assert property (
        wr_ok && paddr_in[13:2] == 12'h207 |-> ##2
        frame_end_comma_out == kchar(comma_w_reg[1:0])) else $error("comma");
    a_comma_mode: assert property (
        $stable(mode_64b66b_in)[*2] ##0 $past(rst_n_in) |->
        comma_valid_out == !mode_64b66b_in) else $error("comma valid");
    a_lane_scale: assert property (
        (first_pair_enable_out ^ second_pair_enable_out)
        && !single_channel_select_out && $stable(full_lanes_in)
        && $stable(full_converters_in) |-> active_lanes_out == lanes_up[4:1]
        && active_converters_out == full_converters_in >> 1
        && tail_pad_out == full_lanes_in[0]) else $error("lane scaling");
    a_linkup_read: assert property (
        rd_st && $stable(link_up_in) |=> prdata_out[6] == $past(link_up_in))
        else $error("link up bit");
    a_sync_read: assert property (
        $stable(sync_n_pin_in)[*4] ##0 rd_st |=>
        prdata_out[5] == $past(sync_n_pin_in)) else $error("sync bit");
    a_pll_read: assert property (
        $stable(pll_pair)[*4] ##0 rd_st |=>
        {prdata_out[2], prdata_out[0]} == $past(pll_pair))
        else $error("pll bits");
    a_realign_set: assert property (
        sysref_phase_shift_in ##1 rd_st |=> prdata_out[4])
        else $error("realign bit");
endmodule

bind slps_regs slps_checker u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .pready_out(pready_out), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .link_up_in(link_up_in),
    .sysref_phase_shift_in(sysref_phase_shift_in),
    .mode_64b66b_in(mode_64b66b_in), .sync_n_pin_in(sync_n_pin_in),
    .serializer_pll_lock_in(serializer_pll_lock_in),
    .converter_pll_lock_in(converter_pll_lock_in),
    .full_lanes_in(full_lanes_in), .full_converters_in(full_converters_in),
    .link_device_number_out(link_device_number_out),
    .frame_end_comma_out(frame_end_comma_out),
    .comma_valid_out(comma_valid_out),
    .first_pair_enable_out(first_pair_enable_out),
    .second_pair_enable_out(second_pair_enable_out),
    .single_channel_select_out(single_channel_select_out),
    .tail_pad_out(tail_pad_out), .active_lanes_out(active_lanes_out),
    .active_converters_out(active_converters_out));

// file: bench/slps_link_model.sv
// Far side model: link core, receiver sync pin and both PLLs.
// Assumes the bench commands power-up and resync, all on clk_in.
`timescale 1ns/1ps
module slps_link_model (
    // Clock, reset and commands
    input  wire  clk_in, rst_n_in, link_enable_in, pll_on_in, want_sync_in,
    // Far side levels and pulses
    output logic link_up_out, sysref_event_out, sync_n_out,
    output logic spll_lock_out, cpll_lock_out
);
    logic [3:0] tick_reg;

    // SYSREF every 16 cycles; receiver holds its sync request until
    // the link runs on locked clocks, so link up never precedes lock
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tick_reg         <= 4'h0;
            sysref_event_out <= 1'b0;
            spll_lock_out    <= 1'b0;
            cpll_lock_out    <= 1'b0;
            sync_n_out       <= 1'b0;
            link_up_out      <= 1'b0;
        end else begin
            tick_reg         <= tick_reg + 4'h1;
            sysref_event_out <= (tick_reg == 4'h0);
            spll_lock_out    <= pll_on_in;
            cpll_lock_out    <= spll_lock_out;
            sync_n_out       <= link_enable_in & cpll_lock_out & !want_sync_in;
            link_up_out      <= sync_n_out & link_enable_in;
        end
    end
endmodule

// file: bench/tb_serial_link_param_status_regs.sv
// Self-checking bench for the link parameter and status bank.
// Assumes the far side model and the bound checker compile first.
`timescale 1ns/1ps
module tb_serial_link_param_status_regs;
    typedef struct {logic [13:0] a; logic [31:0] w, r;} slps_row_t;
    logic        clk_in, rst_n_in, psel_in, penable_in, pwrite_in, err;
    logic [13:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, q;
    logic        pready_out, pslverr_out, link_up_in, sysref_phase_shift_in;
    logic        sysref_event_in, mode_64b66b_in, sync_n_pin_in, irq_out;
    logic        spll_in, cpll_in, pll_on, want_sync, link_en, comma_ok;
    logic        first_en, second_en, single_en, swap, tail;
    logic [3:0]  full_lanes_in, full_converters_in, lanes, convs;
    logic [7:0]  devnum, comma;
    logic [7:0]  kexp [4] = '{8'hfc, 8'h3c, 8'hbc, 8'hfc};
    int          fail_count, n_tests;
    slps_row_t   rows [6] = '{'{14'h818, 32'hffffffa5, 32'ha5},
        '{14'h81c, 32'h2, 32'h2}, '{14'h824, 32'h5, 32'h5},
        '{14'h824, 32'hfa, 32'h2}, '{14'h824, 32'h3, 32'h3},
        '{14'hc08, 32'hf, 32'hf}};

    // 40 ns clock
    initial clk_in = 1'b0;
    always #20 clk_in = ~clk_in;

    slps_regs u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .link_up_in(link_up_in),
        .sysref_phase_shift_in(sysref_phase_shift_in),
        .sysref_event_in(sysref_event_in), .mode_64b66b_in(mode_64b66b_in),
        .full_lanes_in(full_lanes_in),
        .full_converters_in(full_converters_in),
        .sync_n_pin_in(sync_n_pin_in), .serializer_pll_lock_in(spll_in),
        .converter_pll_lock_in(cpll_in), .serial_link_enable_out(link_en),
        .link_device_number_out(devnum), .frame_end_comma_out(comma),
        .comma_valid_out(comma_ok), .first_pair_enable_out(first_en),
        .second_pair_enable_out(second_en),
        .single_channel_select_out(single_en), .pair_swap_out(swap),
        .active_lanes_out(lanes), .active_converters_out(convs),
        .tail_pad_out(tail), .irq_out(irq_out));

    slps_link_model u_far (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .link_enable_in(link_en), .pll_on_in(pll_on),
        .want_sync_in(want_sync), .link_up_out(link_up_in),
        .sysref_event_out(sysref_event_in), .sync_n_out(sync_n_pin_in),
        .spll_lock_out(spll_in), .cpll_lock_out(cpll_in));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer, then an idle cycle so strobes never re-arm at once
    task automatic apb(input logic w, input logic [13:0] a,
                       input logic [31:0] d);
        psel_in   <= 1'b1;
        pwrite_in <= w;
        paddr_in  <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (pready_out !== 1'b1);
        q = prdata_out;
        err = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic rd(input logic [13:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic end_sim;
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Run needs some 190 cycles; 4000 means a hang
    initial begin
        tick(4000);
        fail_count++;
        end_sim;
    end

    initial begin
        {psel_in, penable_in, pwrite_in, rst_n_in} = 4'h0;
        {sysref_phase_shift_in, mode_64b66b_in, pll_on, want_sync} = 4'h0;
        {paddr_in, pwdata_in} = 46'h0;
        {full_lanes_in, full_converters_in} = 8'h54;
        fail_count = 0;
        n_tests = 0;
        tick(10);
        rst_n_in <= 1'b1;
        tick(1);
        rd(14'h818, 32'h0);
        rd(14'h820, 32'h0);
        rd(14'h824, 32'h3);
        chk({24'h0, comma}, 32'hfc);
        $display("reset test done");
        // Link stays off while ID, comma and channels change
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].r);
        end
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, 14'h81c, {30'h0, c[1:0]});
            tick(3);
            chk({24'h0, comma}, {24'h0, kexp[c]});
            chk({31'h0, comma_ok}, 32'h1);
        end
        mode_64b66b_in <= 1'b1;
        tick(3);
        chk({31'h0, comma_ok}, 32'h0);
        mode_64b66b_in <= 1'b0;
        apb(1'b1, 14'h824, 32'h2);
        tick(3);
        chk({19'h0, swap, tail, lanes, convs, first_en, second_en, single_en},
            {19'h0, 2'h3, 4'h3, 4'h2, 3'h2});
        $display("config test done");
        pll_on <= 1'b1;
        apb(1'b1, 14'hc00, 32'h1);
        tick(40);
        rd(14'h820, 32'h6d);
        apb(1'b1, 14'h820, 32'hff);
        rd(14'h820, 32'h65);
        sysref_phase_shift_in <= 1'b1;
        tick(1);
        sysref_phase_shift_in <= 1'b0;
        rd(14'h820, 32'h75);
        rd(14'h820, 32'h75);
        apb(1'b1, 14'h820, 32'h10);
        rd(14'h820, 32'h65);
        // Interrupt raised, masked, unmasked and cleared
        chk({31'h0, irq_out}, 32'h1);
        rd(14'hc04, 32'h3);
        apb(1'b1, 14'hc08, 32'h0);
        tick(2);
        chk({31'h0, irq_out}, 32'h0);
        apb(1'b1, 14'hc08, 32'hf);
        tick(2);
        chk({31'h0, irq_out}, 32'h1);
        apb(1'b1, 14'hc04, 32'h3);
        tick(2);
        chk({31'h0, irq_out}, 32'h0);
        want_sync <= 1'b1;
        tick(10);
        rd(14'h820, 32'h05);
        rd(14'hc04, 32'h4);
        apb(1'b0, 14'hffc, 32'h0);
        chk({q[31:1], err}, 32'h1);
        $display("status test done");
        end_sim;
    end
endmodule
